/* File: sdis_diag_log.sv */
// diagnostic memory: logs one entry per faulted channel per scan cycle, for the channels walked before the next scan restarts the walk
`timescale 1ns/1ps
`default_nettype none
module sdis_diag_log #(
  parameter int NUM_CH = sdis_pkg::NUM_CH,
  parameter int DEPTH  = sdis_pkg::DIAG_DEPTH,
  parameter int CH_W   = $clog2(NUM_CH),
  parameter int AD_W   = $clog2(DEPTH),
  parameter int DW     = 16 + CH_W + sdis_pkg::ERR_W
) (
  input  wire logic                            clk,
  input  wire logic                            reset,
  input  wire logic                            start,
  input  wire logic [NUM_CH*sdis_pkg::ERR_W-1:0] errVec,
  input  wire logic [AD_W-1:0]                 rdAddr,
  output logic      [DW-1:0]                   rdData,
  output logic      [AD_W:0]                   count
);
  localparam int EW = sdis_pkg::ERR_W;
  logic [DW-1:0]          mem [DEPTH];
  logic [NUM_CH*EW-1:0]   snap, next_snap;
  logic [CH_W:0]          idx, next_idx;
  logic [15:0]            cycNum, next_cycNum;
  logic [AD_W-1:0]        wrPtr, next_wrPtr;
  logic [AD_W:0]          next_count;
  logic                   wrEn;
  logic [EW-1:0]          curErr;

  // walk the captured codes one channel per clock; a new scan restarts the walk
  always_comb begin
    next_snap   = snap;
    next_idx    = idx;
    next_cycNum = cycNum;
    next_wrPtr  = wrPtr;
    next_count  = count;
    curErr      = snap[idx[CH_W-1:0]*EW +: EW];
    wrEn        = 1'b0;
    if (start) begin
      next_snap   = errVec;
      next_idx    = '0;
      next_cycNum = cycNum + 16'h0001;
    end else if (idx < (CH_W+1)'(NUM_CH)) begin
      next_idx = idx + 1'b1;
      if (curErr != sdis_pkg::ERR_NONE) begin
        wrEn       = 1'b1;
        next_wrPtr = wrPtr + 1'b1;
        // oldest entries are overwritten, count saturates at depth
        if (count < (AD_W+1)'(DEPTH)) next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      snap   <= '0;
      idx    <= (CH_W+1)'(NUM_CH);
      cycNum <= '0;
      wrPtr  <= '0;
      count  <= '0;
      rdData <= '0;
    end else begin
      snap   <= next_snap;
      idx    <= next_idx;
      cycNum <= next_cycNum;
      wrPtr  <= next_wrPtr;
      count  <= next_count;
      rdData <= mem[rdAddr];
    end
  end

  // memory array carries no reset, entries are only valid below count
  always_ff @(posedge clk) begin
    if (wrEn) mem[wrPtr] <= {cycNum, idx[CH_W-1:0], curErr};
  end
endmodule : sdis_diag_log
`default_nettype wire

/* File: sdis_field_model.sv */
// field wiring model: contacts, self-test readback path and line-control wiring
`timescale 1ns/1ps
`default_nettype none
module sdis_field_model (
  input  wire logic        clk,
  input  wire logic        testEn,
  input  wire logic        testLevel,
  input  wire logic [7:0]  pulseOut,
  input  wire logic [15:0] fieldLevel,
  input  wire logic [15:0] wired,
  input  wire logic [47:0] wireSrc,
  input  wire logic [15:0] crossEn,
  input  wire logic [47:0] crossSrc,
  input  wire logic [15:0] openEn,
  input  wire logic [15:0] echoStuck,
  output logic      [15:0] inRaw,
  output logic      [15:0] chanEcho
);
  logic toggle = 1'b0;

  // readback is not driven outside the test window, so show a changing pattern
  always @(posedge clk) begin
    toggle <= ~toggle;
  end

  // a stuck readback fails the high test; a wired input follows its pulse sources
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      chanEcho[i] = testEn ? (testLevel & ~echoStuck[i]) : (toggle ^ i[0]);
      if (openEn[i]) begin
        inRaw[i] = 1'b0; // broken wire reads low
      end else if (wired[i]) begin
        inRaw[i] = pulseOut[wireSrc[i*3 +: 3]]
                   & (~crossEn[i] | pulseOut[crossSrc[i*3 +: 3]]);
      end else begin
        inRaw[i] = fieldLevel[i];
      end
    end
  end
endmodule : sdis_field_model
`default_nettype wire

/* File: sdis_pkg.sv */
// shared constants for the safe digital input scanner
package sdis_pkg;
  // default geometry
  localparam int NUM_CH  = 16;
  localparam int NUM_SRC = 8;
  localparam int ADC_W   = 12;
  localparam int ERR_W   = 3;
  localparam int DIAG_DEPTH = 16;
  // clock and line-control pulse timing
  localparam int CLK_MHZ       = 250;
  localparam int PULSE_MIN_US  = 5;
  localparam int PULSE_MAX_US  = 2000;
  localparam int CYC_PER_US    = CLK_MHZ;
  localparam int PULSE_MIN_CYC = PULSE_MIN_US * CYC_PER_US;
  localparam int PULSE_MAX_CYC = PULSE_MAX_US * CYC_PER_US;
  // settle time of the channel self-test injection path
  localparam int SETTLE_CYC = 4;
  // per-channel error codes, higher value does not mean higher priority
  localparam logic [ERR_W-1:0] ERR_NONE     = 3'h0;
  localparam logic [ERR_W-1:0] ERR_SELFTEST = 3'h1;
  localparam logic [ERR_W-1:0] ERR_CROSS    = 3'h2;
  localparam logic [ERR_W-1:0] ERR_WRONGSRC = 3'h3;
  localparam logic [ERR_W-1:0] ERR_GROUND   = 3'h4;
  localparam logic [ERR_W-1:0] ERR_OPEN     = 3'h5;
  localparam logic [ERR_W-1:0] ERR_ANALOG   = 3'h6;
  // scan sequencer states
  typedef enum logic [2:0] {
    SDIS_IDLE, SDIS_TEST_LO, SDIS_TEST_HI, SDIS_LINE, SDIS_SAMPLE, SDIS_PUBLISH
  } sdis_state_t;
endpackage : sdis_pkg

/* File: sdis_scanner.sv */
// safe digital input scanner: self-test, line control, sampling and fault substitution
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RULE_01] sample every input once per cycle, hold
// [RULE_02] no pulse stretching between samples
// [RULE_03] self-test proves both levels pass each channel
// [RULE_04] self-test finishes before inputs are sampled
// [RULE_05] faulted input presents its configured initial value
// [RULE_06] each fault yields a readable error code
// [RULE_07] fault lights shared or per-module indicator
// [RULE_08] report via indicators, variables, diagnostic memory
// [RULE_09] application filters surges over two cycles
// [RULE_10] threshold inputs compare digitised value, analog tests
// [RULE_11] line control pulses own outputs into inputs
// [RULE_12] test pulse length configurable 5 to 2000 us
// [RULE_13] any pulse source assignable to any input
// [RULE_14] cross-circuit between parallel wires raises code
// [RULE_15] pulses from unassigned output raise code
// [RULE_16] ground fault code only with grounded reference
// [RULE_17] missing test pulses raise open-circuit code
// [RULE_18] hazardous faults switch off within safety time
// [RULE_19] value and fault status published together
module sdis_scanner #(
  parameter int NUM_CH        = sdis_pkg::NUM_CH,
  parameter int NUM_SRC       = sdis_pkg::NUM_SRC,
  parameter int ADC_W         = sdis_pkg::ADC_W,
  parameter int CH_PER_LED    = sdis_pkg::NUM_CH,
  parameter int PULSE_MIN_CYC = sdis_pkg::PULSE_MIN_CYC,
  parameter int PULSE_MAX_CYC = sdis_pkg::PULSE_MAX_CYC,
  parameter int SW            = $clog2(NUM_SRC),
  parameter int NUM_LED       = NUM_CH / CH_PER_LED,
  parameter int DIAG_AW       = $clog2(sdis_pkg::DIAG_DEPTH),
  parameter int DIAG_DW       = 16 + $clog2(NUM_CH) + sdis_pkg::ERR_W
) (
  input  wire logic                            clk,
  input  wire logic                            reset,
  input  wire logic                            cycleStart,
  input  wire logic [NUM_CH-1:0]               inRaw,
  input  wire logic [NUM_CH-1:0]               chanEcho,
  input  wire logic [NUM_CH*ADC_W-1:0]         adcValue,
  input  wire logic [NUM_CH-1:0]               thrMode,
  input  wire logic [ADC_W-1:0]                thrHigh,
  input  wire logic [ADC_W-1:0]                thrLow,
  input  wire logic [NUM_CH-1:0]               adcFault,
  input  wire logic                            lineEn,
  input  wire logic [NUM_CH-1:0]               lineCh,
  input  wire logic                            groundedRef,
  input  wire logic [10:0]                     pulseUs,
  input  wire logic [NUM_CH*SW-1:0]            pulseSourceAssignment,
  input  wire logic [NUM_CH-1:0]               initValue,
  input  wire logic [NUM_CH-1:0]               safetyCh,
  input  wire logic [DIAG_AW-1:0]              diagRdAddr,
  output logic      [NUM_SRC-1:0]              pulseOut,
  output logic                                 testEn,
  output logic                                 testLevel,
  output logic                                 busy,
  output logic      [NUM_CH-1:0]               chanValue,
  output logic      [NUM_CH*sdis_pkg::ERR_W-1:0] chanErr,
  output logic                                 cycleDone,
  output logic      [NUM_LED-1:0]              faultLed,
  output logic                                 safeOff,
  output logic      [DIAG_DW-1:0]              diagRdData,
  output logic      [DIAG_AW:0]                diagCount
);
  localparam int EW    = sdis_pkg::ERR_W;
  localparam int CNT_W = $clog2(PULSE_MAX_CYC + 1);
  localparam int PI_W  = $clog2(NUM_SRC + 1);

  sdis_pkg::sdis_state_t state, next_state;
  logic [CNT_W-1:0]      cnt, next_cnt;
  logic [PI_W-1:0]       pIdx, next_pIdx;
  logic                  lineRun, next_lineRun;
  logic [NUM_CH-1:0]     stFault, next_stFault;
  logic [NUM_CH-1:0]     base, next_base;
  logic [NUM_CH-1:0]     ownSeen, next_ownSeen;
  logic [NUM_CH-1:0]     otherSeen, next_otherSeen;
  logic [NUM_CH-1:0]     samp, next_samp;
  logic [NUM_CH-1:0]     next_chanValue;
  logic [NUM_CH*EW-1:0]  next_chanErr;
  logic [NUM_CH-1:0]     chFault;
  logic                  next_safeOff;
  logic [CNT_W-1:0]      pulseCyc;
  logic                  sampleStrobe;
  int                    rawCyc;

  // pick the pulse source wired to a channel
  function automatic logic [SW-1:0] srcOf(input logic [NUM_CH*SW-1:0] sel, input int ch);
    srcOf = sel[ch*SW +: SW];
  endfunction : srcOf

  // threshold compare with hysteresis; inside the band the last value is kept
  function automatic logic thrBit(input logic [ADC_W-1:0] v, input logic prev,
                                  input logic [ADC_W-1:0] hi, input logic [ADC_W-1:0] lo);
    thrBit = (v >= hi) ? 1'b1 : ((v <= lo) ? 1'b0 : prev);
  endfunction : thrBit

  // pulse length from microseconds, clamped to the legal window
  always_comb begin
    rawCyc = int'(pulseUs) * sdis_pkg::CYC_PER_US;
    if (rawCyc < PULSE_MIN_CYC) rawCyc = PULSE_MIN_CYC;  // [RULE_12]
    if (rawCyc > PULSE_MAX_CYC) rawCyc = PULSE_MAX_CYC;  // [RULE_12]
    pulseCyc = CNT_W'(rawCyc);
  end

  // decoded drive toward the field, outputs idle high and pulse low
  assign testEn       = (state == sdis_pkg::SDIS_TEST_LO) || (state == sdis_pkg::SDIS_TEST_HI);
  assign testLevel    = (state == sdis_pkg::SDIS_TEST_HI);  // [RULE_03]
  assign busy         = (state != sdis_pkg::SDIS_IDLE);
  assign sampleStrobe = (state == sdis_pkg::SDIS_SAMPLE);
  generate
    for (genvar p = 0; p < NUM_SRC; p++) begin : g_pulse
      assign pulseOut[p] = !(state == sdis_pkg::SDIS_LINE && pIdx == PI_W'(p + 1));  // [RULE_11]
    end
  endgenerate

  // sequencer and per-cycle evidence; a start while busy is ignored
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_pIdx      = pIdx;
    next_lineRun   = lineRun;
    next_stFault   = stFault;
    next_base      = base;
    next_ownSeen   = ownSeen;
    next_otherSeen = otherSeen;
    next_samp      = samp;
    case (state)
      sdis_pkg::SDIS_IDLE: begin
        if (cycleStart) begin
          next_state     = sdis_pkg::SDIS_TEST_LO;
          next_cnt       = CNT_W'(sdis_pkg::SETTLE_CYC - 1);
          next_stFault   = '0;
          next_base      = '1;
          next_ownSeen   = '0;
          next_otherSeen = '0;
          next_lineRun   = lineEn;  // line-control enable is frozen for the whole cycle
        end
      end
      sdis_pkg::SDIS_TEST_LO: begin
        if (cnt == '0) begin
          next_stFault = stFault | chanEcho;  // [RULE_03] must pass a low
          next_state   = sdis_pkg::SDIS_TEST_HI;
          next_cnt     = CNT_W'(sdis_pkg::SETTLE_CYC - 1);
        end else next_cnt = cnt - 1'b1;
      end
      sdis_pkg::SDIS_TEST_HI: begin
        if (cnt == '0) begin
          next_stFault = stFault | ~chanEcho;  // [RULE_03] must pass a high
          next_pIdx    = '0;
          next_cnt     = pulseCyc - 1'b1;
          next_state   = lineRun ? sdis_pkg::SDIS_LINE : sdis_pkg::SDIS_SAMPLE;  // [RULE_04]
        end else next_cnt = cnt - 1'b1;
      end
      sdis_pkg::SDIS_LINE: begin
        // phase 0 is a quiet baseline, phase p+1 pulses source p low
        if (cnt == '0) begin
          if (pIdx == '0) next_base = inRaw;
          else begin
            for (int i = 0; i < NUM_CH; i++) begin
              if (PI_W'(srcOf(pulseSourceAssignment, i)) == pIdx - 1'b1)
                next_ownSeen[i] = ownSeen[i] | ~inRaw[i];  // [RULE_13]
              else
                next_otherSeen[i] = otherSeen[i] | ~inRaw[i];  // [RULE_13]
            end
          end
          if (pIdx == PI_W'(NUM_SRC)) next_state = sdis_pkg::SDIS_SAMPLE;
          else begin
            next_pIdx = pIdx + 1'b1;
            next_cnt  = pulseCyc - 1'b1;
          end
        end else next_cnt = cnt - 1'b1;
      end
      sdis_pkg::SDIS_SAMPLE: begin
        // single snapshot, anything shorter than the cycle may be missed
        for (int i = 0; i < NUM_CH; i++) begin
          next_samp[i] = thrMode[i] ?
            thrBit(adcValue[i*ADC_W +: ADC_W], samp[i], thrHigh, thrLow) :  // [RULE_10]
            inRaw[i];  // [RULE_01] [RULE_02]
        end
        next_state = sdis_pkg::SDIS_PUBLISH;
      end
      sdis_pkg::SDIS_PUBLISH: next_state = sdis_pkg::SDIS_IDLE;
      default: next_state = sdis_pkg::SDIS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= sdis_pkg::SDIS_IDLE;
      cnt       <= '0;
      pIdx      <= '0;
      lineRun   <= 1'b0;
      stFault   <= '0;
      base      <= '1;
      ownSeen   <= '0;
      otherSeen <= '0;
      samp      <= '0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      pIdx      <= next_pIdx;
      lineRun   <= next_lineRun;
      stFault   <= next_stFault;
      base      <= next_base;
      ownSeen   <= next_ownSeen;
      otherSeen <= next_otherSeen;
      samp      <= next_samp;
    end
  end

  // fault classification, self-test first, then analog path, then wiring
  always_comb begin
    next_chanValue = chanValue;
    next_chanErr   = chanErr;
    next_safeOff   = safeOff;
    chFault        = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      logic [EW-1:0] code;
      code = sdis_pkg::ERR_NONE;
      if (stFault[i]) code = sdis_pkg::ERR_SELFTEST;
      else if (thrMode[i] && adcFault[i]) code = sdis_pkg::ERR_ANALOG;  // [RULE_10]
      else if (lineRun && lineCh[i] && !thrMode[i]) begin
        if (!base[i])
          code = groundedRef ? sdis_pkg::ERR_GROUND : sdis_pkg::ERR_OPEN;  // [RULE_16]
        else if (ownSeen[i] && otherSeen[i]) code = sdis_pkg::ERR_CROSS;  // [RULE_14]
        else if (otherSeen[i]) code = sdis_pkg::ERR_WRONGSRC;  // [RULE_15]
        else if (!ownSeen[i]) code = sdis_pkg::ERR_OPEN;  // [RULE_17]
      end
      chFault[i] = (code != sdis_pkg::ERR_NONE);
      if (state == sdis_pkg::SDIS_PUBLISH) begin
        next_chanValue[i]         = chFault[i] ? initValue[i] : samp[i];  // [RULE_05] [RULE_19]
        next_chanErr[i*EW +: EW]  = code;  // [RULE_06] [RULE_19]
      end
    end
    // latched until reset: a hazardous fault forces the restart path
    if (state == sdis_pkg::SDIS_PUBLISH && |(chFault & safetyCh))
      next_safeOff = 1'b1;  // [RULE_18]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      chanValue <= '0;
      chanErr   <= '0;
      safeOff   <= 1'b0;
      cycleDone <= 1'b0;
    end else begin
      chanValue <= next_chanValue;
      chanErr   <= next_chanErr;
      safeOff   <= next_safeOff;
      cycleDone <= (state == sdis_pkg::SDIS_PUBLISH);
    end
  end

  // one indicator per group; a single group gives the shared compact lamp
  generate
    for (genvar g = 0; g < NUM_LED; g++) begin : g_led
      logic errAny;
      always_comb begin
        errAny = 1'b0;
        for (int i = g * CH_PER_LED; i < (g + 1) * CH_PER_LED; i++)
          errAny = errAny | (chanErr[i*EW +: EW] != sdis_pkg::ERR_NONE);
      end
      assign faultLed[g] = errAny;  // [RULE_07] [RULE_08]
    end
  endgenerate

  // diagnostic memory, read by the programming terminal
  sdis_diag_log #(
    .NUM_CH (NUM_CH),
    .DEPTH  (sdis_pkg::DIAG_DEPTH)
  ) u_diag (
    .clk    (clk),
    .reset  (reset),
    .start  (cycleDone),
    .errVec (chanErr),
    .rdAddr (diagRdAddr),
    .rdData (diagRdData),
    .count  (diagCount)
  );  // [RULE_08]

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // helper: samples taken since the current scan began
  logic [1:0] sampCnt;
  always_ff @(posedge clk) begin
    if (reset || (state == sdis_pkg::SDIS_IDLE)) sampCnt <= '0;
    else if (sampleStrobe && sampCnt != 2'h3) sampCnt <= sampCnt + 2'h1;
  end

  chk_one_sample: assert property (sampCnt <= 2'h1)  // [RULE_01]
    else $error("more than one sample in a scan");
  chk_sample_raw: assert property (sampleStrobe && !thrMode[0] |=> samp[0] == $past(inRaw[0]))  // [RULE_02]
    else $error("sample does not match input");
  chk_test_first: assert property (sampleStrobe |-> $past(state) != sdis_pkg::SDIS_IDLE && !testEn)  // [RULE_04]
    else $error("sample taken without preceding self-test");
  chk_test_levels: assert property ($rose(testEn) |-> !testLevel ##4 testLevel)  // [RULE_03]
    else $error("self-test levels out of order");
  chk_subst_init: assert property (state == sdis_pkg::SDIS_PUBLISH && stFault[0] |=> chanValue[0] == $past(initValue[0]))  // [RULE_05]
    else $error("faulted input not substituted");
  chk_err_code: assert property (state == sdis_pkg::SDIS_PUBLISH && stFault[0] |=> chanErr[EW-1:0] == sdis_pkg::ERR_SELFTEST)  // [RULE_06]
    else $error("self-test fault code missing");
  chk_value_hold: assert property (!$past(state == sdis_pkg::SDIS_PUBLISH) |-> $stable(chanValue) && $stable(chanErr))  // [RULE_19]
    else $error("outputs changed outside publish");
  chk_fault_led: assert property (cycleDone |-> (|faultLed) == (chanErr != '0))  // [RULE_07]
    else $error("fault indicator disagrees with codes");
  chk_pulse_gate: assert property (!(&pulseOut) |-> lineRun && state == sdis_pkg::SDIS_LINE)  // [RULE_11]
    else $error("test pulse without line control");
  chk_safe_off: assert property (state == sdis_pkg::SDIS_PUBLISH && |(chFault & safetyCh) |=> safeOff)  // [RULE_18]
    else $error("safe state not entered");
  chk_ground_ref: assert property (cycleDone && !$past(groundedRef, 2) |-> chanErr[EW-1:0] != sdis_pkg::ERR_GROUND)  // [RULE_16]
    else $error("ground fault without grounded reference");
endmodule : sdis_scanner
`default_nettype wire

/* File: tb.sv */
// self-checking testbench for the safe digital input scanner
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int PCYC = 40;
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  logic         cycleStart = 1'b0;
  logic [15:0]  fieldLevel = '0, wired = '0, crossEn = '0, openEn = '0, echoStuck = '0;
  logic [15:0]  thrMode = '0, adcFault = '0, lineCh = '0, initValue = 16'h0004, safetyCh = '0;
  logic [47:0]  wireSrc = '0, crossSrc = '0, pulseSourceAssignment = '0;
  logic [191:0] adcValue = '0;
  logic [11:0]  thrHigh = 12'h800, thrLow = 12'h400;
  logic         lineEn = 1'b0, groundedRef = 1'b0;
  logic [10:0]  pulseUs = 11'h005;
  logic [3:0]   diagRdAddr = '0;
  logic [15:0]  inRaw, chanEcho, chanValue;
  logic [7:0]   pulseOut;
  logic         testEn, testLevel, busy, cycleDone, safeOff;
  logic [47:0]  chanErr;
  logic [0:0]   faultLed;
  logic [22:0]  diagRdData;
  logic [4:0]   diagCount;
  int           badCount = 0;
  int           testsRun = 0;

  always #2 clk = ~clk;

  sdis_scanner #(.PULSE_MIN_CYC(10), .PULSE_MAX_CYC(PCYC)) sdis_scanner_i (
    .clk(clk), .reset(reset), .cycleStart(cycleStart), .inRaw(inRaw), .chanEcho(chanEcho),
    .adcValue(adcValue), .thrMode(thrMode), .thrHigh(thrHigh), .thrLow(thrLow),
    .adcFault(adcFault), .lineEn(lineEn), .lineCh(lineCh), .groundedRef(groundedRef),
    .pulseUs(pulseUs), .pulseSourceAssignment(pulseSourceAssignment), .initValue(initValue),
    .safetyCh(safetyCh), .diagRdAddr(diagRdAddr), .pulseOut(pulseOut), .testEn(testEn),
    .testLevel(testLevel), .busy(busy), .chanValue(chanValue), .chanErr(chanErr),
    .cycleDone(cycleDone), .faultLed(faultLed), .safeOff(safeOff),
    .diagRdData(diagRdData), .diagCount(diagCount));

  sdis_field_model sdis_field_model_i (
    .clk(clk), .testEn(testEn), .testLevel(testLevel), .pulseOut(pulseOut),
    .fieldLevel(fieldLevel), .wired(wired), .wireSrc(wireSrc), .crossEn(crossEn),
    .crossSrc(crossSrc), .openEn(openEn), .echoStuck(echoStuck), .inRaw(inRaw),
    .chanEcho(chanEcho));

  task automatic completeRun();
    $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : completeRun

  // four-state compare, so an unknown never passes
  task automatic cmpVec(input logic [63:0] got, input logic [63:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmpVec

  task automatic cmpInt(input int got, input int exp, input string what);
    testsRun++;
    if (got != exp) begin
      badCount++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : cmpInt

  task automatic resetDut();
    reset = 1'b1;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    // the first start goes in the cycle after the edge that sees reset low
    @(negedge clk);
  endtask : resetDut

  // one scan; poke repeats the start while busy, which must be ignored
  task automatic runScan(input int expEdges, input bit poke);
    int n;
    cycleStart = 1'b1;
    @(negedge clk);
    n = 1;
    while (cycleDone !== 1'b1 && n < 1000) begin
      if (n == 1) begin
        cmpVec({busy, testEn, testLevel}, 3'b110, "test low phase");
      end
      cycleStart = poke && (n == 2);
      @(negedge clk);
      n++;
    end
    cmpInt(n, expEdges, "scan latency");
    cmpVec(busy, 1'b0, "busy at done");
    if (n >= 1000) begin
      completeRun();
    end
  endtask : runScan

  task automatic scReset();
    cmpVec({chanValue, chanErr}, '0, "reset values");
    cmpVec({cycleDone, busy, safeOff, faultLed, diagCount, pulseOut, testEn}, 18'h001fe, "idle");
  endtask : scReset

  task automatic scPlain();
    fieldLevel = 16'ha5c0;
    runScan(11, 1'b1);
    cmpVec(chanValue, 16'ha5c0, "plain values");
    cmpVec({chanErr, faultLed}, '0, "plain codes");
    fieldLevel = 16'h5a3f;
    repeat (5) @(negedge clk);
    cmpVec({chanValue, busy}, {16'ha5c0, 1'b0}, "held values");
    // a level standing over two scans shows in two published values, so a filter can accept it
    runScan(11, 1'b0);
    cmpVec(chanValue, 16'h5a3f, "level after next scan");
  endtask : scPlain

  task automatic scSelfTest();
    fieldLevel = 16'ha5c0;
    echoStuck = 16'h0004;
    safetyCh = 16'h0004;
    runScan(11, 1'b0);
    cmpVec(chanValue, 16'ha5c4, "substituted value");
    cmpVec(chanErr, {45'h0, sdis_pkg::ERR_SELFTEST} << 6, "selftest code");
    cmpVec({faultLed, safeOff}, 2'b11, "indicator and off");
    repeat (20) @(negedge clk);
    // the analog fault of the threshold scan is logged first, the self-test fault second
    cmpVec(diagCount, 5'h02, "diag count");
    cmpVec(diagRdData, {16'h0003, 4'h7, sdis_pkg::ERR_ANALOG}, "diag entry 0");
    diagRdAddr = 4'h1;
    @(negedge clk);
    cmpVec(diagRdData, {16'h0004, 4'h2, sdis_pkg::ERR_SELFTEST}, "diag entry 1");
    echoStuck = '0;
    runScan(11, 1'b0);
    cmpVec({chanErr, safeOff}, {48'h0, 1'b1}, "sticky off");
    safetyCh = '0;
    resetDut();
    cmpVec(safeOff, 1'b0, "off cleared");
  endtask : scSelfTest

  task automatic scThreshold();
    thrMode = 16'h00e0;
    adcFault = 16'h0080;
    adcValue[5*12 +: 12] = 12'h900;
    adcValue[6*12 +: 12] = 12'h100;
    adcValue[7*12 +: 12] = 12'hfff;
    fieldLevel = 16'h0040;
    runScan(11, 1'b0);
    cmpVec(chanValue, 16'h0020, "threshold values");
    cmpVec(chanErr, {45'h0, sdis_pkg::ERR_ANALOG} << 21, "analog code");
    thrMode = '0;
    adcFault = '0;
  endtask : scThreshold

  task automatic scLine(input bit gnd);
    logic [47:0] e;
    e = '0;
    e[3 +: 3] = sdis_pkg::ERR_CROSS;
    e[6 +: 3] = sdis_pkg::ERR_WRONGSRC;
    e[9 +: 3] = gnd ? sdis_pkg::ERR_GROUND : sdis_pkg::ERR_OPEN;
    e[12 +: 3] = sdis_pkg::ERR_OPEN;
    groundedRef = gnd;
    runScan(11 + 9 * PCYC, 1'b0);
    cmpVec(chanValue, 16'h0001, "line values");
    cmpVec(chanErr, e, "line codes");
    cmpVec({faultLed, pulseOut}, 9'h1ff, "line idle");
  endtask : scLine

  // main sequence: scans run back to back where one follows another
  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    scReset();
    scPlain();
    scThreshold();
    scSelfTest();
    lineEn = 1'b1;
    lineCh = 16'h001f;
    initValue = 16'h0000;
    fieldLevel = 16'h0010;
    wired = 16'h0007;
    wireSrc[3 +: 3] = 3'h1;
    wireSrc[6 +: 3] = 3'h3;
    crossEn = 16'h0002;
    crossSrc[3 +: 3] = 3'h2;
    openEn = 16'h0008;
    pulseSourceAssignment[3 +: 3] = 3'h1;
    pulseSourceAssignment[6 +: 3] = 3'h2;
    pulseSourceAssignment[9 +: 3] = 3'h4;
    pulseSourceAssignment[12 +: 3] = 3'h7;
    scLine(1'b0);
    scLine(1'b1);
    completeRun();
  end
endmodule : tb
`default_nettype wire
